// file: sim/rtc_only_power_control_test.sv
// Self-checking bench of the RTC power sequencer and its APB register.
// Assumes the partner model supplies the wake pulse and the supply comparator.
`timescale 1ns/1ps
module rtc_only_power_control_test;
   logic        clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic        alarm = 0, wake_req = 0;
   logic [15:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata, d;
   logic        pready, pslverr, wake_pin, wake_o, oe_n, supply, core_on, por_on, bg_on;
   logic        ok, iso, sys_rst_n, clk_out;
   logic [32:0] exp_q[$];
   logic [7:0]  rnd = 8'h12;
   int          num_errors = 0;
   int          checks_done = 0;
   localparam logic [32:0] ERR = 33'h1_0000_0000;

   // Clock of 4 ns period.
   initial
   begin
      forever #2 clk = ~clk;
   end

   rtcpc_top #(.WAKE_MIN_CYCLES(4), .BANDGAP_SETTLE_CYCLES(16)) rtcpc_top_inst (
      .CLK(clk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hf), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .WAKE_PIN_I(wake_pin), .WAKE_PIN_O(wake_o), .WAKE_PIN_OE_N(oe_n),
      .RTC_ALARM(alarm), .SUPPLY_ABOVE_THRESHOLD(supply), .CORE_REGULATOR_OUTPUT_ON(core_on),
      .ANALOG_POR_ON(por_on), .BANDGAP_ON(bg_on), .SUPPLY_OK_SIGNAL(ok), .RTC_ISOLATE(iso),
      .SYSTEM_RESET_N(sys_rst_n), .CLOCK_OUT(clk_out));

   rtcpc_power_partner rtcpc_power_partner_inst (
      .clk(clk), .pulse_req(wake_req), .wake_oe_n(oe_n), .core_on(core_on),
      .wake_pin(wake_pin), .supply_above(supply));

   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // Eight-bit Fibonacci shift register that supplies the random register values.
   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      lfsr_next = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr_next

   // Lets the edge updates land before anything is looked at.
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   task automatic wait_iso(input logic v);
      repeat (100) if (iso !== v) tick(1);
      chk(iso, v);
   endtask : wait_iso

   // One APB transfer; the expected answer goes to the queue for the monitor.
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] wd, input logic [32:0] e);
      @(posedge clk);
      exp_q.push_back(e);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic finish_test;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : finish_test

   // Compares each answer with the oldest note.
   always @(posedge clk)
      if (pready === 1'b1)
         chk({pslverr, prdata}, exp_q.size() ? exp_q.pop_front() : 33'hx);

   // Cuts a hang short.
   initial
   begin
      #(4 * 40000);
      num_errors++;
      finish_test;
   end

   initial
   begin
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      wait_iso(1'b0);
      chk(ok, 1'b1);
      chk(sys_rst_n, 1'b0);
      tick(10);
      chk(sys_rst_n, 1'b1);
      apb(1'b0, 16'h1930, 0, 33'h10);
      apb(1'b0, 16'h1940, 0, ERR);
      repeat (4)
      begin
         rnd = lfsr_next(rnd);
         d = {4{rnd}} & 32'hfffffff9;
         apb(1'b1, 16'h1930, d, 0);
         apb(1'b0, 16'h1930, 0, {28'h0, d[4:0]});
         tick(1);
         chk({wake_o, oe_n}, {1'b0, !(d[3] && !d[4])});
      end
      apb(1'b1, 16'h1930, 1, 0);
      repeat (8000) if (clk_out !== 1'b1) tick(1);
      chk(clk_out, 1'b1);
      apb(1'b1, 16'h1930, 0, 0);
      tick(3);
      chk(clk_out, 1'b0);
      apb(1'b1, 16'h1930, 32'h1a, 0);
      tick(3);
      chk({core_on, por_on, bg_on, ok, iso, oe_n}, 6'h0b);
      apb(1'b1, 16'h1930, 0, ERR);
      @(posedge clk) wake_req <= 1'b1;
      @(posedge clk) wake_req <= 1'b0;
      tick(20);
      chk(core_on, 1'b0);
      @(posedge clk) alarm <= 1'b1;
      @(posedge clk) alarm <= 1'b0;
      tick(2);
      chk({core_on, ok, iso}, 3'b101);
      wait_iso(1'b0);
      tick(10);
      apb(1'b0, 16'h1930, 0, 33'h18);
      apb(1'b0, 16'h1934, 0, 33'h0c);
      apb(1'b1, 16'h1930, 32'h4, 0);
      tick(3);
      chk({core_on, por_on, bg_on}, 3'b000);
      @(posedge clk) wake_req <= 1'b1;
      @(posedge clk) wake_req <= 1'b0;
      wait_iso(1'b0);
      chk({core_on, por_on, bg_on}, 3'b111);
      tick(10);
      apb(1'b0, 16'h1930, 0, 33'h0);
      tick(2);
      finish_test;
   end
endmodule : rtc_only_power_control_test

// file: sim/rtcpc_power_partner.sv
// Far side of the wake pin and the core supply comparator.
// Assumes one clock shared with the bench; pulse_req is a one-cycle request.
`timescale 1ns/1ps
module rtcpc_power_partner
#(
   parameter int PULSE_CYCLES = 6,
   parameter int RAMP_CYCLES  = 5
)
(
   input  wire logic clk,
   input  wire logic pulse_req,
   input  wire logic wake_oe_n,
   input  wire logic core_on,
   output logic      wake_pin,
   output logic      supply_above = 1'b0
);
   int cnt  = 0;
   int ramp = 0;

   // The circuit drives low between pulses, so the pull-up never fakes a wake.
   assign wake_pin = wake_oe_n ? (cnt != 0) : 1'b0;

   // A wake pulse spans at least one slow period, scaled down here.
   always @(posedge clk)
   begin
      if (pulse_req && cnt == 0)
         cnt <= PULSE_CYCLES;
      else if (cnt != 0)
         cnt <= cnt - 1;
   end

   // The comparator trips only after the regulator has ramped for a while.
   always @(posedge clk)
   begin
      if (!core_on)
      begin
         ramp         <= 0;
         supply_above <= 1'b0;
      end
      else if (ramp < RAMP_CYCLES)
         ramp <= ramp + 1;
      else
         supply_above <= 1'b1;
   end
endmodule : rtcpc_power_partner

// file: src/rtcpc_pin_if.sv
// Carrier between the pin conditioning module and the sequencer core.
// Assumes both ends run on the same clock; all signals are already synchronised.
`timescale 1ns/1ps
interface rtcpc_pin_if;
   logic wake_level;
   logic wake_valid;
   logic supply_above;

   modport filt (output wake_level, output wake_valid, output supply_above);
   modport core (input wake_level, input wake_valid, input supply_above);
endinterface : rtcpc_pin_if

// file: src/rtcpc_pkg.sv
// Constants, register layout and state encoding of the RTC-only power control block.
// Assumes a single 250 MHz clock; every slower rate is derived by counting.
package rtcpc_pkg;

   // Clock and derived timing.
   localparam int unsigned CLK_FREQ_MHZ           = 250;
   localparam int unsigned CLK_FREQ_HZ            = 250_000_000;
   localparam int unsigned RTC_CLK_HZ             = 32768;
   localparam int unsigned WAKE_MIN_TIME_NS       = 30500;
   localparam int unsigned WAKE_MIN_CYCLES_DEF    = (WAKE_MIN_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
   localparam int unsigned BG_SETTLE_TIME_MS      = 100;
   localparam int unsigned BG_SETTLE_CYCLES_DEF   = BG_SETTLE_TIME_MS * CLK_FREQ_MHZ * 1000;
   localparam int unsigned RTC_HALF_CYCLES        = CLK_FREQ_HZ / (2 * RTC_CLK_HZ);
   localparam int unsigned RESET_HOLD_CYCLES      = 8;

   // Counter widths.
   localparam int          WAKE_CNT_W             = 13;
   localparam int          SETTLE_CNT_W           = 25;
   localparam int          CLKDIV_W               = 12;
   localparam int          RST_CNT_W              = 4;

   // Bus and register map.
   localparam int          ADDR_W                 = 16;
   localparam int          DATA_W                 = 32;
   localparam logic [15:0] PMGT_ADDR              = 16'h1930;
   localparam logic [15:0] STATUS_ADDR            = 16'h1934;

   // Power management register fields; bits above PMGT_W read as zero.
   localparam int          PMGT_W                 = 5;
   localparam int          PMGT_CLKOUT_BIT        = 0;
   localparam int          PMGT_REG_PD_BIT        = 1;
   localparam int          PMGT_BANDGAP_POWERDOWN_BIT         = 2;
   localparam int          PMGT_DIR_BIT           = 3;
   localparam int          PMGT_LEVEL_BIT         = 4;
   localparam logic [4:0]  PMGT_RESET             = 5'h10;

   // Status register fields.
   localparam int          STAT_STATE_LSB         = 0;
   localparam int          STAT_SUPPLY_BIT        = 2;
   localparam int          STAT_BGREADY_BIT       = 3;
   localparam int          STAT_WAKE_BIT          = 4;

   // Sequencer states, Gray coded along active, off, ramp, reset.
   typedef enum logic [1:0]
   {
      ST_ACTIVE = 2'b00,
      ST_OFF    = 2'b01,
      ST_RAMP   = 2'b11,
      ST_RESET  = 2'b10
   } rtcpc_state_t;

endpackage : rtcpc_pkg

// file: src/rtcpc_top.sv
// Power sequencer of the always-on RTC domain with its APB power management register.
// Assumes an APB master on CLK, an analog supply comparator and an open-drain wake pin with a pull-up.
`timescale 1ns/1ps
module rtcpc_top
#(
   parameter int unsigned WAKE_MIN_CYCLES       = rtcpc_pkg::WAKE_MIN_CYCLES_DEF,
   parameter int unsigned BANDGAP_SETTLE_CYCLES = rtcpc_pkg::BG_SETTLE_CYCLES_DEF
)
(
   input  wire logic        CLK,
   input  wire logic        RESET_N,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [15:0] PADDR,
   input  wire logic [31:0] PWDATA,
   input  wire logic [3:0]  PSTRB,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic        WAKE_PIN_I,
   output logic             WAKE_PIN_O,
   output logic             WAKE_PIN_OE_N,
   input  wire logic        RTC_ALARM,
   input  wire logic        SUPPLY_ABOVE_THRESHOLD,
   output logic             CORE_REGULATOR_OUTPUT_ON,
   output logic             ANALOG_POR_ON,
   output logic             BANDGAP_ON,
   output logic             SUPPLY_OK_SIGNAL,
   output logic             RTC_ISOLATE,
   output logic             SYSTEM_RESET_N,
   output logic             CLOCK_OUT
);
   localparam int SW = rtcpc_pkg::SETTLE_CNT_W;
   localparam int CW = rtcpc_pkg::CLKDIV_W;
   localparam int RW = rtcpc_pkg::RST_CNT_W;
   localparam int PW = rtcpc_pkg::PMGT_W;
   localparam logic [SW-1:0] SETTLE_LAST = SW'(BANDGAP_SETTLE_CYCLES - 1);
   localparam logic [CW-1:0] HALF_LAST   = CW'(rtcpc_pkg::RTC_HALF_CYCLES - 1);
   localparam logic [RW-1:0] RST_LAST    = RW'(rtcpc_pkg::RESET_HOLD_CYCLES - 1);

   logic                    rst_meta;
   logic                    rst_n;
   rtcpc_pkg::rtcpc_state_t state;
   rtcpc_pkg::rtcpc_state_t next_state;
   logic                    bg_mode;
   logic                    next_bg_mode;
   logic [RW-1:0]           rst_cnt;
   logic [RW-1:0]           next_rst_cnt;
   logic [PW-1:0]           pmgt;
   logic [PW-1:0]           next_pmgt;
   logic [SW-1:0]           settle_cnt;
   logic [SW-1:0]           next_settle_cnt;
   logic                    bg_ready;
   logic                    next_bg_ready;
   logic [CW-1:0]           div_cnt;
   logic [CW-1:0]           next_div_cnt;
   logic                    rtc_phase;
   logic                    next_rtc_phase;
   logic [31:0]             next_prdata;
   logic                    next_pready;
   logic                    next_pslverr;
   logic                    next_core_on;
   logic                    next_bg_on;
   logic                    next_supply_ok;
   logic                    next_sysrst_n;
   logic                    next_oe_n;
   logic                    next_clock_out;
   logic                    wr_take;
   logic                    wake_req;

   rtcpc_pin_if pin_bus ();

   // Pin conditioning lives apart so that the wake pin and the supply comparator are synchronised in one place.
   rtcpc_wake_filter #(.WAKE_MIN_CYCLES(WAKE_MIN_CYCLES)) u_filter
   (
      .clk          (CLK),
      .rst_n        (rst_n),
      .wake_pin_raw (WAKE_PIN_I),
      .supply_raw   (SUPPLY_ABOVE_THRESHOLD),
      .pin          (pin_bus.filt)
   );

   // Reset release synchroniser; assertion is immediate, release waits two edges.
   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // Address decode used by the error answer; the read path compares PADDR itself.
   function automatic logic addr_mapped(input logic [15:0] addr);
      if (addr == rtcpc_pkg::PMGT_ADDR)
      begin
         addr_mapped = 1'b1;
      end
      else if (addr == rtcpc_pkg::STATUS_ADDR)
      begin
         addr_mapped = 1'b1;
      end
      else
      begin
         addr_mapped = 1'b0;
      end
   endfunction : addr_mapped

   // The write lands at the access edge where PREADY is seen, and only if the answer was not an error.
   assign wr_take  = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR && (PADDR == rtcpc_pkg::PMGT_ADDR);
   // An input-configured pin or an alarm may wake; an output-configured pin is our own driver.
   assign wake_req = RTC_ALARM || (pin_bus.wake_valid && !pmgt[rtcpc_pkg::PMGT_DIR_BIT]);

   // Sequencer and register next values; hardware clearing of the power-down bits wins over a write.
   always_comb
   begin
      next_state   = state;
      next_bg_mode = bg_mode;
      next_rst_cnt = rst_cnt;
      next_pmgt    = pmgt;
      if (wr_take && PSTRB[0])
      begin
         next_pmgt = PWDATA[PW-1:0];
      end
      case (state)
         rtcpc_pkg::ST_ACTIVE:
         begin
            if (pmgt[rtcpc_pkg::PMGT_REG_PD_BIT] || pmgt[rtcpc_pkg::PMGT_BANDGAP_POWERDOWN_BIT])
            begin
               next_state   = rtcpc_pkg::ST_OFF;
               next_bg_mode = pmgt[rtcpc_pkg::PMGT_BANDGAP_POWERDOWN_BIT];
            end
         end
         rtcpc_pkg::ST_OFF:
         begin
            if (wake_req)
            begin
               next_state                            = rtcpc_pkg::ST_RAMP;
               next_pmgt[rtcpc_pkg::PMGT_REG_PD_BIT] = 1'b0;
               next_pmgt[rtcpc_pkg::PMGT_BANDGAP_POWERDOWN_BIT]  = 1'b0;
            end
         end
         rtcpc_pkg::ST_RAMP:
         begin
            if (pin_bus.supply_above)
            begin
               next_state   = rtcpc_pkg::ST_RESET;
               next_rst_cnt = '0;
            end
         end
         default:
         begin
            next_rst_cnt = rst_cnt + RW'(1);
            if (rst_cnt == RST_LAST)
            begin
               next_state = rtcpc_pkg::ST_ACTIVE;
            end
         end
      endcase
   end

   // Output values follow the next state so that each registered output matches the state it sits in.
   always_comb
   begin
      next_core_on   = (next_state != rtcpc_pkg::ST_OFF);
      next_bg_on     = !((next_state == rtcpc_pkg::ST_OFF) && next_bg_mode);
      next_supply_ok = (next_state == rtcpc_pkg::ST_RESET) || (next_state == rtcpc_pkg::ST_ACTIVE);
      next_sysrst_n  = (next_state == rtcpc_pkg::ST_ACTIVE);
      next_oe_n      = !(next_pmgt[rtcpc_pkg::PMGT_DIR_BIT] && !next_pmgt[rtcpc_pkg::PMGT_LEVEL_BIT]);
      next_clock_out = next_rtc_phase && next_pmgt[rtcpc_pkg::PMGT_CLKOUT_BIT];
   end

   // RTC-rate divider and bandgap recharge timer; the timer restarts whenever the bandgap is off.
   always_comb
   begin
      next_div_cnt    = div_cnt + CW'(1);
      next_rtc_phase  = rtc_phase;
      next_settle_cnt = settle_cnt;
      next_bg_ready   = bg_ready;
      if (div_cnt == HALF_LAST)
      begin
         next_div_cnt   = '0;
         next_rtc_phase = !rtc_phase;
      end
      if (!next_bg_on)
      begin
         next_settle_cnt = '0;
         next_bg_ready   = 1'b0;
      end
      else if (settle_cnt != SETTLE_LAST)
      begin
         next_settle_cnt = settle_cnt + SW'(1);
      end
      else
      begin
         next_bg_ready = 1'b1;
      end
   end

   // APB answer is prepared in the setup cycle, so PREADY is high in the first access cycle.
   always_comb
   begin
      next_pready  = PSEL && !PENABLE;
      next_pslverr = 1'b0;
      next_prdata  = '0;
      if (PSEL && !PENABLE)
      begin
         if (RTC_ISOLATE || !addr_mapped(PADDR))
         begin
            next_pslverr = 1'b1;
         end
         else if (!PWRITE && (PADDR == rtcpc_pkg::PMGT_ADDR))
         begin
            next_prdata = {{(32 - PW){1'b0}}, pmgt};
         end
         else if (!PWRITE)
         begin
            next_prdata[rtcpc_pkg::STAT_STATE_LSB +: 2]  = state;
            next_prdata[rtcpc_pkg::STAT_SUPPLY_BIT]      = SUPPLY_OK_SIGNAL;
            next_prdata[rtcpc_pkg::STAT_BGREADY_BIT]     = bg_ready;
            next_prdata[rtcpc_pkg::STAT_WAKE_BIT]        = pin_bus.wake_level;
         end
      end
   end

   // All state but the reset synchroniser, and every output register; after reset the core waits for its supply like a wake.
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state                    <= rtcpc_pkg::ST_RAMP;
         bg_mode                  <= 1'b0;
         rst_cnt                  <= '0;
         pmgt                     <= rtcpc_pkg::PMGT_RESET;
         settle_cnt               <= '0;
         bg_ready                 <= 1'b0;
         div_cnt                  <= '0;
         rtc_phase                <= 1'b0;
         PRDATA                   <= '0;
         PREADY                   <= 1'b0;
         PSLVERR                  <= 1'b0;
         WAKE_PIN_O               <= 1'b0;
         WAKE_PIN_OE_N            <= 1'b1;
         CORE_REGULATOR_OUTPUT_ON <= 1'b1;
         ANALOG_POR_ON            <= 1'b1;
         BANDGAP_ON               <= 1'b1;
         SUPPLY_OK_SIGNAL         <= 1'b0;
         RTC_ISOLATE              <= 1'b1;
         SYSTEM_RESET_N           <= 1'b0;
         CLOCK_OUT                <= 1'b0;
      end
      else
      begin
         state                    <= next_state;
         bg_mode                  <= next_bg_mode;
         rst_cnt                  <= next_rst_cnt;
         pmgt                     <= next_pmgt;
         settle_cnt               <= next_settle_cnt;
         bg_ready                 <= next_bg_ready;
         div_cnt                  <= next_div_cnt;
         rtc_phase                <= next_rtc_phase;
         PRDATA                   <= next_prdata;
         PREADY                   <= next_pready;
         PSLVERR                  <= next_pslverr;
         WAKE_PIN_O               <= 1'b0;
         WAKE_PIN_OE_N            <= next_oe_n;
         CORE_REGULATOR_OUTPUT_ON <= next_core_on;
         ANALOG_POR_ON            <= next_core_on;
         BANDGAP_ON               <= next_bg_on;
         SUPPLY_OK_SIGNAL         <= next_supply_ok;
         RTC_ISOLATE              <= !next_supply_ok;
         SYSTEM_RESET_N           <= next_sysrst_n;
         CLOCK_OUT                <= next_clock_out;
      end
   end

   // Checks on the sequencer, the pin driver and the register file.
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!rst_n);

   sequence s_reset_window;
      (!SYSTEM_RESET_N)[*8] ##1 SYSTEM_RESET_N;
   endsequence

   sequence s_powered_down;
      !CORE_REGULATOR_OUTPUT_ON && !SUPPLY_OK_SIGNAL && RTC_ISOLATE;
   endsequence

   property p_pd_entry;
      (state == rtcpc_pkg::ST_ACTIVE) && (pmgt[rtcpc_pkg::PMGT_REG_PD_BIT] || pmgt[rtcpc_pkg::PMGT_BANDGAP_POWERDOWN_BIT])
         |=> s_powered_down;
   endproperty
   a_pd_entry: assert property (p_pd_entry) else $error("power-down did not isolate");

   property p_ramp_hold;
      (state == rtcpc_pkg::ST_RAMP) && !pin_bus.supply_above |=> !SUPPLY_OK_SIGNAL && RTC_ISOLATE;
   endproperty
   a_ramp_hold: assert property (p_ramp_hold) else $error("supply-good rose before threshold");

   property p_supply_rise;
      $rose(SUPPLY_OK_SIGNAL) |-> !RTC_ISOLATE and s_reset_window;
   endproperty
   a_supply_rise: assert property (p_supply_rise) else $error("wrong reset after supply-good");

   property p_pin_drive;
      pmgt[rtcpc_pkg::PMGT_DIR_BIT] && !pmgt[rtcpc_pkg::PMGT_LEVEL_BIT] |-> !WAKE_PIN_OE_N && !WAKE_PIN_O;
   endproperty
   a_pin_drive: assert property (p_pin_drive) else $error("wake pin not driven low");

   property p_pin_release;
      !pmgt[rtcpc_pkg::PMGT_DIR_BIT] || pmgt[rtcpc_pkg::PMGT_LEVEL_BIT] |-> WAKE_PIN_OE_N;
   endproperty
   a_pin_release: assert property (p_pin_release) else $error("wake pin driven while released");

   property p_output_no_wake;
      (state == rtcpc_pkg::ST_OFF) && pmgt[rtcpc_pkg::PMGT_DIR_BIT] && !RTC_ALARM
         |=> state == rtcpc_pkg::ST_OFF;
   endproperty
   a_output_no_wake: assert property (p_output_no_wake) else $error("woke through output pin");

   property p_bg_off;
      (state == rtcpc_pkg::ST_OFF) |-> !ANALOG_POR_ON && (BANDGAP_ON == !bg_mode);
   endproperty
   a_bg_off: assert property (p_bg_off) else $error("bandgap state wrong in power-down");

   property p_alarm_wake;
      (state == rtcpc_pkg::ST_OFF) && RTC_ALARM |=> CORE_REGULATOR_OUTPUT_ON && ANALOG_POR_ON && BANDGAP_ON
         && !pmgt[rtcpc_pkg::PMGT_REG_PD_BIT] && !pmgt[rtcpc_pkg::PMGT_BANDGAP_POWERDOWN_BIT];
   endproperty
   a_alarm_wake: assert property (p_alarm_wake) else $error("alarm did not wake");

   property p_reserved_zero;
      PREADY && !PSLVERR && (PADDR == rtcpc_pkg::PMGT_ADDR) |-> PRDATA[31:PW] == '0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero");

   property p_clkout_gate;
      !pmgt[rtcpc_pkg::PMGT_CLKOUT_BIT] |-> !CLOCK_OUT;
   endproperty
   a_clkout_gate: assert property (p_clkout_gate) else $error("clock out while disabled");

   property p_isolated_write;
      $past(RTC_ISOLATE) && PSEL && PENABLE && PREADY && PWRITE |-> PSLVERR ##1 $stable(pmgt);
   endproperty
   a_isolated_write: assert property (p_isolated_write) else $error("write accepted while isolated");

endmodule : rtcpc_top

// file: src/rtcpc_wake_filter.sv
// Synchronises the wake pin and the supply monitor and qualifies the wake pulse width.
// Assumes raw inputs are asynchronous to clk and rst_n is already synchronised.
`timescale 1ns/1ps
module rtcpc_wake_filter
#(
   parameter int unsigned WAKE_MIN_CYCLES = rtcpc_pkg::WAKE_MIN_CYCLES_DEF
)
(
   input  wire logic      clk,
   input  wire logic      rst_n,
   input  wire logic      wake_pin_raw,
   input  wire logic      supply_raw,
   rtcpc_pin_if.filt      pin
);
   localparam int WW = rtcpc_pkg::WAKE_CNT_W;
   localparam logic [WW-1:0] WAKE_LAST = WW'(WAKE_MIN_CYCLES - 1);

   logic          wake_meta;
   logic          wake_sync;
   logic          supply_meta;
   logic          supply_sync;
   logic [WW-1:0] high_cnt;
   logic [WW-1:0] next_high_cnt;
   logic          wake_valid;
   logic          next_wake_valid;

   // A pulse shorter than the minimum never wakes the core, which rejects glitches on the pin.
   always_comb
   begin
      next_high_cnt   = high_cnt;
      next_wake_valid = 1'b0;
      if (!wake_sync)
      begin
         next_high_cnt = '0;
      end
      else if (high_cnt != WAKE_LAST)
      begin
         next_high_cnt = high_cnt + WW'(1);
      end
      else
      begin
         next_wake_valid = 1'b1;
      end
   end

   // Two-stage synchronisers; the first stage feeds only the second.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wake_meta   <= 1'b0;
         wake_sync   <= 1'b0;
         supply_meta <= 1'b0;
         supply_sync <= 1'b0;
         high_cnt    <= '0;
         wake_valid  <= 1'b0;
      end
      else
      begin
         wake_meta   <= wake_pin_raw;
         wake_sync   <= wake_meta;
         supply_meta <= supply_raw;
         supply_sync <= supply_meta;
         high_cnt    <= next_high_cnt;
         wake_valid  <= next_wake_valid;
      end
   end

   // Valid stays high while the pin stays high past the minimum width.
   assign pin.wake_level   = wake_sync;
   assign pin.wake_valid   = wake_valid;
   assign pin.supply_above = supply_sync;

endmodule : rtcpc_wake_filter
